//--- core/sa_cfg.svh
// offsets, field positions, reset values and timing counts of the evaluator
`ifndef SA_CFG_SVH
`define SA_CFG_SVH
`define SA_CLK_PERIOD_NS 10
`define SA_METER_CYCLE_NS 1000000000
`define SA_METER_CYCLE_CLKS (`SA_METER_CYCLE_NS / `SA_CLK_PERIOD_NS)
`define SA_CHAT_WIN_LAST 4'h9
`define SA_CHAT_MAX_SHORT 4'h4
`define SA_CHAT_MAX_LONG 5'h0a
`define SA_OFS_CTRL 8'h00
`define SA_OFS_CMD 8'h04
`define SA_OFS_PU_THR 8'h08
`define SA_OFS_DO_THR 8'h0c
`define SA_OFS_SP_DLY 8'h10
`define SA_OFS_DIG_DLY 8'h14
`define SA_OFS_ACT_MASK 8'h18
`define SA_OFS_STATUS 8'h1c
`define SA_OFS_TS_START 8'h20
`define SA_OFS_TS_END 8'h24
`define SA_OFS_PEAK_PU 8'h28
`define SA_OFS_PEAK_AL 8'h2c
`define SA_CTRL_SP_EN 0
`define SA_CTRL_UNDER 1
`define SA_CTRL_3PH 2
`define SA_CTRL_DIG_EN 3
`define SA_CMD_REEN 0
`define SA_CMD_UCLR 8
`define SA_MASK_RELAY 8
`define SA_RST_CTRL 5'h00
`define SA_RST_THR 32'h0000_0000
`define SA_RST_DLY 32'h0000_0000
`define SA_RST_MASK 15'h0000
`endif

//--- core/sa_evaluator.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "sa_cfg.svh"
module sa_evaluator
  import sa_pkg::*;
#(
  parameter int unsigned CYCLE_CLKS = `SA_METER_CYCLE_CLKS
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic powerup_i,
  input wire logic reset_evt_i,
  input wire logic diag_fault_i,
  input wire logic phase_rev_i,
  input wire logic status_input_one_i,
  input wire logic status_input_two_i,
  input wire logic [31:0] meas_a_i,
  input wire logic [31:0] meas_b_i,
  input wire logic [31:0] meas_c_i,
  input wire logic [31:0] timestamp_i,
  output logic alarm_start_event_o,
  output logic alarm_end_event_o,
  output logic [6:0] alarm_active_o,
  output logic dout_o,
  output logic relay_o
);

  function automatic sa_trk_t sa_step(input sa_trk_t t, input logic pu,
                                      input logic dn, input logic [15:0] pd,
                                      input logic [15:0] dd);
    sa_trk_t n;
    n = t;
    case (t.st)
      SA_IDLE:
        if (pu)
        begin
          n.st = (pd == 16'h0000) ? SA_ACTIVE : SA_PICKUP;
          n.cnt = (pd == 16'h0000) ? 16'h0000 : 16'h0001;
        end
      SA_PICKUP:
        if (!pu)
        begin
          n.st = SA_IDLE;
          n.cnt = 16'h0000;
        end
        else if (t.cnt >= pd)
        begin
          n.st = SA_ACTIVE;
          n.cnt = 16'h0000;
        end
        else
          n.cnt = t.cnt + 16'h0001;
      SA_ACTIVE:
        if (dn)
        begin
          n.st = (dd == 16'h0000) ? SA_IDLE : SA_DROPOUT;
          n.cnt = (dd == 16'h0000) ? 16'h0000 : 16'h0001;
        end
      SA_DROPOUT:
        if (!dn)
        begin
          n.st = SA_ACTIVE;
          n.cnt = 16'h0000;
        end
        else if (t.cnt >= dd)
        begin
          n.st = SA_IDLE;
          n.cnt = 16'h0000;
        end
        else
          n.cnt = t.cnt + 16'h0001;
      default:
      begin
        n.st = SA_IDLE;
        n.cnt = 16'h0000;
      end
    endcase
    return n;
  endfunction : sa_step

  function automatic logic [31:0] sa_ext(input logic [31:0] a,
                                         input logic [31:0] b,
                                         input logic under);
    return under ? ((a < b) ? a : b) : ((a > b) ? a : b);
  endfunction : sa_ext

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  //////////////////////////////////////////////////////////////////////////
  // meter cycle divider

  logic [31:0] div_r;
  logic tick_r;
  logic [3:0] win_r;
  wire div_wrap = (div_r == 32'(CYCLE_CLKS - 1));
  wire win_last = (win_r == `SA_CHAT_WIN_LAST);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      div_r <= 32'h0000_0000;
      tick_r <= 1'b0;
      win_r <= 4'h0;
    end
    else
    begin
      div_r <= div_wrap ? 32'h0000_0000 : div_r + 32'h0000_0001;
      tick_r <= div_wrap;
      if (tick_r)
        win_r <= win_last ? 4'h0 : win_r + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register bus

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [4:0] ctrl_r;
  logic [31:0] pu_thr_r;
  logic [31:0] do_thr_r;
  logic [31:0] sp_dly_r;
  logic [31:0] dig_dly_r;
  logic [14:0] mask_r;
  logic [3:0] unary_r;
  logic [1:0] dig_dis_r;
  logic sp_act_r;
  logic [31:0] ts_start_r;
  logic [31:0] ts_end_r;
  logic [31:0] peak_pu_r;
  logic [31:0] peak_al_r;
  logic [4:0] act;

  wire apb_acc = psel_i & penable_i;
  wire apb_wr = apb_acc & pready_r & pwrite_i;
  wire sel_ctrl = (paddr_i == `SA_OFS_CTRL);
  wire sel_cmd = (paddr_i == `SA_OFS_CMD);
  wire sel_put = (paddr_i == `SA_OFS_PU_THR);
  wire sel_dot = (paddr_i == `SA_OFS_DO_THR);
  wire sel_spd = (paddr_i == `SA_OFS_SP_DLY);
  wire sel_dgd = (paddr_i == `SA_OFS_DIG_DLY);
  wire sel_msk = (paddr_i == `SA_OFS_ACT_MASK);
  wire sel_sts = (paddr_i == `SA_OFS_STATUS);
  wire sel_tss = (paddr_i == `SA_OFS_TS_START);
  wire sel_tse = (paddr_i == `SA_OFS_TS_END);
  wire sel_ppu = (paddr_i == `SA_OFS_PEAK_PU);
  wire sel_pal = (paddr_i == `SA_OFS_PEAK_AL);
  wire addr_ok = |{sel_ctrl, sel_cmd, sel_put, sel_dot, sel_spd, sel_dgd,
                   sel_msk, sel_sts, sel_tss, sel_tse, sel_ppu, sel_pal};
  wire [31:0] status_word = {20'h00000, act[2:0], sp_act_r, dig_dis_r,
                             act[4:3], unary_r};
  wire [31:0] rd_data =
    sel_ctrl ? {27'h0000000, ctrl_r} :
    sel_put ? pu_thr_r :
    sel_dot ? do_thr_r :
    sel_spd ? sp_dly_r :
    sel_dgd ? dig_dly_r :
    sel_msk ? {17'h00000, mask_r} :
    sel_sts ? status_word :
    sel_tss ? ts_start_r :
    sel_tse ? ts_end_r :
    sel_ppu ? peak_pu_r :
    sel_pal ? peak_al_r : 32'h0000_0000;
  wire cmd_wr = apb_wr & sel_cmd;
  wire [1:0] reen = cmd_wr ? pwdata_i[`SA_CMD_REEN +: 2] : 2'h0;
  wire [3:0] uclr = cmd_wr ? pwdata_i[`SA_CMD_UCLR +: 4] : 4'h0;
  wire sp_en = ctrl_r[`SA_CTRL_SP_EN];
  wire under = ctrl_r[`SA_CTRL_UNDER];
  wire three = ctrl_r[`SA_CTRL_3PH];

  // one wait state keeps every bus output straight from a flop
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= apb_acc & ~pready_r;
      if (apb_acc & ~pready_r)
      begin
        pslverr_r <= ~addr_ok;
        prdata_r <= pwrite_i ? 32'h0000_0000 : rd_data;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= `SA_RST_CTRL;
      pu_thr_r <= `SA_RST_THR;
      do_thr_r <= `SA_RST_THR;
      sp_dly_r <= `SA_RST_DLY;
      dig_dly_r <= `SA_RST_DLY;
      mask_r <= `SA_RST_MASK;
    end
    else if (apb_wr)
    begin
      if (sel_ctrl)
        ctrl_r <= pwdata_i[4:0];
      if (sel_put)
        pu_thr_r <= pwdata_i;
      if (sel_dot)
        do_thr_r <= pwdata_i;
      if (sel_spd)
        sp_dly_r <= pwdata_i;
      if (sel_dgd)
        dig_dly_r <= pwdata_i;
      if (sel_msk)
        mask_r <= pwdata_i[14:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // single-condition alarms and chatter guard

  wire [3:0] unary_set = {phase_rev_i, diag_fault_i, reset_evt_i, powerup_i};
  wire [1:0] din = {status_input_two_i, status_input_one_i};
  logic [1:0] din_r;
  logic [3:0] c1_r [2];
  logic [4:0] c10_r [2];
  logic [1:0] chat_trip;

  generate
    for (genvar d = 0; d < 2; d++)
    begin : g_chat
      wire tog = din[d] ^ din_r[d];
      assign chat_trip[d] = (c1_r[d] > `SA_CHAT_MAX_SHORT) |
                            (c10_r[d] > `SA_CHAT_MAX_LONG);
      always_ff @(posedge ref_clk_i)
      begin
        if (!rst_n_i)
        begin
          din_r[d] <= 1'b0;
          c1_r[d] <= 4'h0;
          c10_r[d] <= 5'h00;
        end
        else
        begin
          din_r[d] <= din[d];
          if (tick_r)
            c1_r[d] <= {3'h0, tog};
          else if (c1_r[d] != 4'hf)
            c1_r[d] <= c1_r[d] + {3'h0, tog};
          if (tick_r & win_last)
            c10_r[d] <= {4'h0, tog};
          else if (c10_r[d] != 5'h1f)
            c10_r[d] <= c10_r[d] + {4'h0, tog};
        end
      end
    end
  endgenerate

  // a new event wins over a clear arriving in the same cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      unary_r <= 4'h0;
      dig_dis_r <= 2'h0;
    end
    else
    begin
      unary_r <= unary_set | (unary_r & ~uclr);
      dig_dis_r <= chat_trip | (dig_dis_r & ~reen);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pickup and dropout trackers: three phases, then two status inputs

  wire [31:0] meas [3];
  assign meas[0] = meas_a_i;
  assign meas[1] = meas_b_i;
  assign meas[2] = meas_c_i;
  logic [4:0] pu_c;
  logic [4:0] do_c;
  logic [4:0] en;
  logic [15:0] pu_d [5];
  logic [15:0] do_d [5];
  sa_trk_t trk_r [5];

  generate
    for (genvar g = 0; g < 5; g++)
    begin : g_trk
      if (g < 3)
      begin : g_ph
        assign pu_c[g] = under ? (meas[g] < pu_thr_r) :
                                 (meas[g] > pu_thr_r);
        assign do_c[g] = under ? (meas[g] > do_thr_r) :
                                 (meas[g] < do_thr_r);
        assign pu_d[g] = sp_dly_r[15:0];
        assign do_d[g] = sp_dly_r[31:16];
        assign en[g] = sp_en & ((g == 0) | three);
      end
      else
      begin : g_dig
        assign pu_c[g] = din[g-3];
        assign do_c[g] = ~din[g-3];
        assign pu_d[g] = {8'h00, dig_dly_r[16*(g-3) +: 8]};
        assign do_d[g] = {8'h00, dig_dly_r[16*(g-3)+8 +: 8]};
        assign en[g] = ctrl_r[`SA_CTRL_DIG_EN+g-3] & ~dig_dis_r[g-3];
      end
      assign act[g] = (trk_r[g].st == SA_ACTIVE) |
                      (trk_r[g].st == SA_DROPOUT);
      always_ff @(posedge ref_clk_i)
      begin
        if (!rst_n_i || !en[g])
          trk_r[g] <= '{SA_IDLE, 16'h0000};
        else if (tick_r)
          trk_r[g] <= sa_step(trk_r[g], pu_c[g], do_c[g],
                              pu_d[g], do_d[g]);
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // combined alarm, timestamps and extreme values

  logic [31:0] cur_ext;
  logic pu_zone_r;
  logic in_al_r;
  logic start_evt_r;
  logic end_evt_r;
  wire any_ph = |act[2:0];
  wire pu_zone = |(pu_c[2:0] & en[2:0]);

  always_comb
  begin
    cur_ext = under ? 32'hffff_ffff : 32'h0000_0000;
    for (int k = 0; k < 3; k++)
      if (en[k])
        cur_ext = sa_ext(cur_ext, meas[k], under);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sp_act_r <= 1'b0;
      start_evt_r <= 1'b0;
      end_evt_r <= 1'b0;
      ts_start_r <= 32'h0000_0000;
      ts_end_r <= 32'h0000_0000;
    end
    else
    begin
      sp_act_r <= any_ph;
      start_evt_r <= any_ph & ~sp_act_r;
      end_evt_r <= ~any_ph & sp_act_r;
      if (any_ph & ~sp_act_r)
        ts_start_r <= timestamp_i;
      if (~any_ph & sp_act_r)
        ts_end_r <= timestamp_i;
    end
  end

  // the sample that completes pickup still counts toward the pickup peak
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      pu_zone_r <= 1'b0;
      in_al_r <= 1'b0;
      peak_pu_r <= 32'h0000_0000;
      peak_al_r <= 32'h0000_0000;
    end
    else if (tick_r)
    begin
      in_al_r <= any_ph;
      pu_zone_r <= pu_zone & ~any_ph;
      if (any_ph)
        peak_al_r <= in_al_r ? sa_ext(peak_al_r, cur_ext, under) :
                               cur_ext;
      else if (pu_zone)
        peak_pu_r <= pu_zone_r ? sa_ext(peak_pu_r, cur_ext, under) :
                                 cur_ext;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assigned actions

  logic [6:0] alm_r;
  logic dout_r;
  logic relay_r;
  wire [6:0] alm_vec = {sp_act_r, act[4:3], unary_r};
  wire [6:0] alm_rise = alm_vec & ~alm_r;
  wire relay_trig = |(alm_rise & mask_r[`SA_MASK_RELAY +: 7]);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      alm_r <= 7'h00;
      dout_r <= 1'b0;
      relay_r <= 1'b0;
    end
    else
    begin
      alm_r <= alm_vec;
      dout_r <= |(alm_vec & mask_r[6:0]);
      // pulse lasts until the next meter cycle boundary
      if (relay_trig)
        relay_r <= 1'b1;
      else if (tick_r)
        relay_r <= 1'b0;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign alarm_start_event_o = start_evt_r;
  assign alarm_end_event_o = end_evt_r;
  assign alarm_active_o = alm_r;
  assign dout_o = dout_r;
  assign relay_o = relay_r;

  //////////////////////////////////////////////////////////////////////////
  // checks

  AST_UNARY: assert property (
    (|unary_set) |=> ((unary_r & $past(unary_set)) == $past(unary_set)))
    else $error("unary event not latched");
  AST_DIG_ZERO: assert property (
    tick_r && en[3] && trk_r[3].st == SA_IDLE && pu_c[3] &&
    pu_d[3] == 16'h0000 && en[3] |=> act[3])
    else $error("input alarm missed zero-delay pickup");
  AST_CHAT_TRIP: assert property (
    chat_trip[0] |=> dig_dis_r[0])
    else $error("chatter did not disable input alarm");
  AST_CHAT_HOLD: assert property (
    dig_dis_r[0] && !reen[0] |=> dig_dis_r[0] && !en[3])
    else $error("chatter disable released without command");
  AST_EVAL: assert property (
    !tick_r && en[0] |=> trk_r[0] == $past(trk_r[0]))
    else $error("phase tracker moved off the meter cycle");
  AST_SP_ANY: assert property (
    sp_act_r == $past(any_ph))
    else $error("combined alarm differs from phase states");
  AST_RESTART: assert property (
    tick_r && en[0] && trk_r[0].st == SA_PICKUP && !pu_c[0]
    |=> trk_r[0].st == SA_IDLE && trk_r[0].cnt == 16'h0000)
    else $error("pickup count not restarted");
  AST_TS_START: assert property (
    $rose(sp_act_r) |-> start_evt_r && ts_start_r == $past(timestamp_i))
    else $error("start timestamp not captured");
  AST_TS_END: assert property (
    $fell(sp_act_r) |-> end_evt_r && ts_end_r == $past(timestamp_i))
    else $error("end timestamp not captured");
  AST_PEAK_AL: assert property (
    tick_r && any_ph && !under |=> peak_al_r >= $past(cur_ext))
    else $error("alarm peak below current value");
  AST_RELAY: assert property (
    $rose(relay_r) |-> $past(relay_trig))
    else $error("relay pulsed without a trigger");

endmodule : sa_evaluator

//--- core/sa_pkg.sv
// types shared by the setpoint alarm evaluator
package sa_pkg;
  typedef enum logic [1:0] {
    SA_IDLE = 2'b00,
    SA_PICKUP = 2'b01,
    SA_ACTIVE = 2'b11,
    SA_DROPOUT = 2'b10
  } sa_trk_state_t;
  typedef struct packed {
    sa_trk_state_t st;
    logic [15:0] cnt;
  } sa_trk_t;
endpackage : sa_pkg

//--- test/sa_meas_model.sv
// stand-in for the measurement engine, the status inputs and the clock
`timescale 1ns/100ps
module sa_meas_model
#(
  parameter int unsigned CYCLE_CLKS = 20
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] val_a_i,
  input wire logic [31:0] val_b_i,
  input wire logic [31:0] val_c_i,
  input wire logic lvl_one_i,
  input wire logic lvl_two_i,
  input wire logic chat_go_i,
  output logic [31:0] meas_a_o,
  output logic [31:0] meas_b_o,
  output logic [31:0] meas_c_o,
  output logic status_input_one_o,
  output logic status_input_two_o,
  output logic [31:0] timestamp_o
);
  logic [31:0] sub_r;
  logic [3:0] chat_r;
  logic flip_r;
  ////////////////////////////////////////////////////////////////////////
  // seconds step half a meter cycle away from the tick, so a capture
  // at alarm start or end never races the clock update
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sub_r <= '0;
      timestamp_o <= 32'h0000_1000;
      chat_r <= 4'h0;
      flip_r <= 1'b0;
    end
    else
    begin
      sub_r <= (sub_r == CYCLE_CLKS - 1) ? '0 : sub_r + 1;
      if (sub_r == CYCLE_CLKS / 2 - 1)
        timestamp_o <= timestamp_o + 32'h1;
      // ten toggles on consecutive clocks: at least five land in one window
      if (chat_go_i)
        chat_r <= 4'ha;
      else if (chat_r != 4'h0)
      begin
        chat_r <= chat_r - 4'h1;
        flip_r <= ~flip_r;
      end
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    meas_a_o <= val_a_i;
    meas_b_o <= val_b_i;
    meas_c_o <= val_c_i;
  end
  assign status_input_one_o = lvl_one_i ^ flip_r;
  assign status_input_two_o = lvl_two_i;
endmodule : sa_meas_model

//--- test/tb.sv
// self-checking bench for the setpoint alarm evaluator
`timescale 1ns/100ps
`include "sa_cfg.svh"
module tb;
  localparam int C = 20;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic err;} sa_row_t;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] unary_v = 4'h0;
  logic [31:0] val_a = 32'ha, val_b = 32'ha, val_c = 32'ha;
  logic lvl1 = 1'b0, lvl2 = 1'b0, chat_go = 1'b0;
  logic [31:0] prdata_o, meas_a, meas_b, meas_c, ts, rdata, ts_st, ts_en;
  logic pready_o, pslverr_o, s1, s2, start_o, end_o, dout_o, relay_o, perr;
  logic [6:0] act;
  int mismatches = 0, check_count = 0, starts = 0, ends = 0;
  sa_row_t rows [12] = '{
    '{1'b0, `SA_OFS_CTRL, 32'h0, 1'b0},
    '{1'b0, `SA_OFS_STATUS, 32'h0, 1'b0},
    '{1'b0, `SA_OFS_TS_START, 32'h0, 1'b0},
    '{1'b0, `SA_OFS_PEAK_AL, 32'h0, 1'b0},
    '{1'b1, `SA_OFS_PU_THR, 32'h1234_5678, 1'b0},
    '{1'b0, `SA_OFS_PU_THR, 32'h1234_5678, 1'b0},
    '{1'b1, `SA_OFS_SP_DLY, 32'h0003_0002, 1'b0},
    '{1'b0, `SA_OFS_SP_DLY, 32'h0003_0002, 1'b0},
    '{1'b1, `SA_OFS_STATUS, 32'h1ff, 1'b0},
    '{1'b0, `SA_OFS_STATUS, 32'h0, 1'b0},
    '{1'b0, 8'h30, 32'h0, 1'b1},
    '{1'b1, 8'h40, 32'h5, 1'b1}};
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    if (start_o === 1'b1)
    begin
      starts++;
      ts_st = ts;
    end
    if (end_o === 1'b1)
    begin
      ends++;
      ts_en = ts;
    end
  end
  sa_evaluator #(.CYCLE_CLKS(C)) u_dut (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .powerup_i(unary_v[0]), .reset_evt_i(unary_v[1]),
    .diag_fault_i(unary_v[2]), .phase_rev_i(unary_v[3]),
    .status_input_one_i(s1), .status_input_two_i(s2), .meas_a_i(meas_a),
    .meas_b_i(meas_b), .meas_c_i(meas_c), .timestamp_i(ts),
    .alarm_start_event_o(start_o), .alarm_end_event_o(end_o),
    .alarm_active_o(act), .dout_o(dout_o), .relay_o(relay_o));
  sa_meas_model #(.CYCLE_CLKS(C)) u_meas (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .val_a_i(val_a), .val_b_i(val_b), .val_c_i(val_c),
    .lvl_one_i(lvl1), .lvl_two_i(lvl2), .chat_go_i(chat_go),
    .meas_a_o(meas_a), .meas_b_o(meas_b), .meas_c_o(meas_c),
    .status_input_one_o(s1), .status_input_two_o(s2), .timestamp_o(ts));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 40);
    if (n >= 40)
      mismatches++;
    rdata = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd
  task waitc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : waitc
  // the tick follows half a meter cycle after the seconds change
  task sync;
    @(ts);
    @(posedge ref_clk_i);
  endtask : sync
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(400 * C * 10);
    mismatches++;
    finish_test;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    waitc(1);
    chk({23'h0, act, dout_o, relay_o}, 32'h0);
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(32'(perr), 32'(rows[i].err));
      if (!rows[i].wr)
        chk(rdata, rows[i].d);
    end
    $display("test registers done");
    wr(`SA_OFS_ACT_MASK, 32'h0000_0f0f);
    for (int i = 0; i < 4; i++)
    begin
      sync;
      unary_v <= 4'h1 << i;
      waitc(1);
      unary_v <= 4'h0;
      waitc(3);
      chk(32'(act), 32'h1 << i);
      chk(32'(dout_o), 32'h1);
      chk(32'(relay_o), 32'h1);
      waitc(C + 2);
      chk(32'(relay_o), 32'h0);
      wr(`SA_OFS_CMD, 32'h100 << i);
      waitc(2);
      chk({23'h0, act, dout_o, relay_o}, 32'h0);
    end
    $display("test unary done");
    wr(`SA_OFS_PU_THR, 32'd100);
    wr(`SA_OFS_DO_THR, 32'd50);
    wr(`SA_OFS_SP_DLY, 32'h0001_0002);
    wr(`SA_OFS_ACT_MASK, 32'h0000_0040);
    wr(`SA_OFS_CTRL, 32'h5);
    val_b <= 32'd200;
    waitc(2 * C);
    rd(`SA_OFS_STATUS, 32'h0);
    waitc(2 * C);
    rd(`SA_OFS_STATUS, 32'h500);
    chk(32'(dout_o), 32'h1);
    chk(starts, 32'h1);
    rd(`SA_OFS_TS_START, ts_st);
    val_b <= 32'd300;
    waitc(2 * C);
    rd(`SA_OFS_PEAK_PU, 32'd200);
    rd(`SA_OFS_PEAK_AL, 32'd300);
    val_a <= 32'd300;
    waitc(4 * C);
    val_b <= 32'd10;
    waitc(4 * C);
    rd(`SA_OFS_STATUS, 32'h300);
    sync;
    val_a <= 32'd10;
    waitc(C);
    chk(32'(act[6]), 32'h1);
    waitc(2 * C);
    chk(32'(act[6]), 32'h0);
    chk(ends, 32'h1);
    rd(`SA_OFS_TS_END, ts_en);
    sync;
    val_a <= 32'd200;
    waitc(2 * C);
    val_a <= 32'd10;
    waitc(C);
    val_a <= 32'd200;
    waitc(2 * C);
    chk(32'(act[6]), 32'h0);
    // switch to under before the next tick so phase a cannot pick up as over
    val_a <= 32'd120;
    $display("test over done");
    wr(`SA_OFS_CTRL, 32'h3);
    wr(`SA_OFS_SP_DLY, 32'h0);
    wr(`SA_OFS_DO_THR, 32'd150);
    sync;
    val_a <= 32'd60;
    waitc(C);
    chk(32'(act[6]), 32'h1);
    val_a <= 32'd40;
    waitc(C);
    rd(`SA_OFS_PEAK_AL, 32'd40);
    chk(32'(act[6]), 32'h1);
    val_a <= 32'd200;
    waitc(C + 2);
    chk(32'(act[6]), 32'h0);
    $display("test under done");
    wr(`SA_OFS_CTRL, 32'h18);
    wr(`SA_OFS_DIG_DLY, 32'h0004_0100);
    sync;
    lvl1 <= 1'b1;
    lvl2 <= 1'b1;
    waitc(3 * C);
    chk(32'(act[5:4]), 32'h1);
    waitc(3 * C);
    chk(32'(act[5:4]), 32'h3);
    lvl1 <= 1'b0;
    lvl2 <= 1'b0;
    waitc(C);
    chk(32'(act[5:4]), 32'h1);
    waitc(C);
    chk(32'(act[5:4]), 32'h0);
    lvl1 <= 1'b1;
    waitc(3 * C);
    chat_go <= 1'b1;
    waitc(1);
    chat_go <= 1'b0;
    waitc(14);
    rd(`SA_OFS_STATUS, 32'h40);
    waitc(12 * C);
    rd(`SA_OFS_STATUS, 32'h40);
    wr(`SA_OFS_CMD, 32'h1);
    waitc(3 * C);
    rd(`SA_OFS_STATUS, 32'h10);
    $display("test inputs done");
    finish_test;
  end
endmodule : tb
